// >>> logic/dbgc_core.sv
/*
 * Debug command core: takes command bytes from the serial front end,
 * runs status, control, memory and breakpoint commands and returns
 * answer bytes. Assumes a byte shifter outside with a valid/ready
 * handshake and a CPU bus port that acknowledges each access.
 */
// Notes on behaviour
// - Pin low after debug reset: start halted
// - Pin high after debug reset: start running
// - Enabled halt command halts after current instruction
// - Halt command ignored while debug disabled
// - Sixteen cycle gap after halt command
// - Code E4 returns status byte
// - Status register only reachable by commands
// - Status shows wait/stop and debug active
// - Read-only flags kept; enable sticky while active
// - Debug enable clears on normal reset
// - Enable keeps oscillator running in stop
// - Breakpoint enable and force/tag steer breakpoint
// - Plain read returns data, no status
// - Code E1: address, delay, status, data
// - Access during wait/stop entry sets fail
// - Code C0: address, data, no status
// - Code C1 returns status; fail cancels write
// - Code E2 returns breakpoint match register
// - Code 90 is halt command
// - Code C4 with one control byte
// - Code E0: address, delay, data
// - Code 18 resets in any mode
module dbgc_core
    import dbgc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic cmd_ready,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic debug_pin_level,
    input wire logic cpu_wait_stop,
    input wire logic cpu_entering_wait_stop,
    input wire logic cpu_instr_done,
    input wire logic bp_wr_valid,
    input wire logic [15:0] bp_wr_data,
    output logic halt_req,
    output logic debug_active,
    output logic reset_req,
    output logic osc_keep_on,
    output logic bp_enable,
    output logic force_tag_select,
    output logic [15:0] bp_match
);
    import dbgc_pkg::*;

    dbgc_core_type c_r;
    dbgc_core_type c_nxt;
    dbgc_halt_if hi ();

    // Register kept inside the core, never on the CPU bus
    function automatic logic [7:0] status_byte(
        input dbgc_core_type c,
        input logic active,
        input logic ws
    );
        logic [7:0] b;
        b = 8'h00;
        b[STAT_DEBUG_ENABLE_POS] = c.en;
        b[STAT_DEBUG_ACTIVE_POS] = active;
        b[STAT_BP_ENABLE_POS] = c.bpen;
        b[STAT_FORCE_TAG_POS] = c.force_tag_select_bit;
        b[STAT_WAIT_STOP_POS] = ws;
        b[STAT_WAIT_STOP_FAIL_POS] = c.wait_stop_fail_flag;
        return b;
    endfunction

    function automatic logic is_write(input logic [7:0] cmd);
        return (cmd == CMD_MEM_WRITE) || (cmd == CMD_CHECKED_MEM_WRITE);
    endfunction

    function automatic logic is_checked(input logic [7:0] cmd);
        return (cmd == CMD_CHECKED_MEM_READ) || (cmd == CMD_CHECKED_MEM_WRITE);
    endfunction

    dbgc_halt u_halt (
        .mclk(mclk),
        .rst(rst),
        .hi(hi)
    );

    assign hi.halt_cmd = c_r.halt_pulse;
    assign hi.enable = c_r.en;
    assign hi.pin_level = debug_pin_level;
    assign hi.instr_done = cpu_instr_done;

    always_comb
    begin
        c_nxt = c_r;
        c_nxt.halt_pulse = 1'b0;
        // Reset request held for a fixed count
        if (c_r.rst_cnt != 4'h0)
        begin
            c_nxt.rst_cnt = c_r.rst_cnt - 4'h1;
        end
        else
        begin
            c_nxt.rst_req = 1'b0;
        end
        // Halted out of reset: keep debug enabled
        if (hi.boot_halt)
        begin
            c_nxt.en = 1'b1;
        end
        // Breakpoint load path stands for the separate write command
        if (bp_wr_valid)
        begin
            c_nxt.bp = bp_wr_data;
        end
        unique case (c_r.st)
            S_IDLE:
            begin
                if (rx_valid)
                begin
                    c_nxt.cmd = rx_byte;
                    unique case (rx_byte)
                        CMD_DEBUG_RESET:
                        begin
                            // Taken in any CPU mode
                            c_nxt.rst_req = 1'b1;
                            c_nxt.rst_cnt = RESET_REQ_LOAD;
                        end
                        CMD_HALT:
                        begin
                            c_nxt.halt_pulse = 1'b1;
                            c_nxt.gap = HALT_GAP_LOAD;
                            c_nxt.st = S_HALT_WAIT;
                        end
                        CMD_READ_STATUS:
                        begin
                            c_nxt.tx_byte = status_byte(c_r, hi.active, cpu_wait_stop);
                            c_nxt.tx_valid = 1'b1;
                            c_nxt.has_sec = 1'b0;
                            c_nxt.st = S_TX1;
                        end
                        CMD_WRITE_CONTROL:
                        begin
                            c_nxt.st = S_CTRL;
                        end
                        CMD_MEM_READ, CMD_CHECKED_MEM_READ, CMD_MEM_WRITE,
                        CMD_CHECKED_MEM_WRITE:
                        begin
                            c_nxt.st = S_ADDR_HI;
                        end
                        CMD_BP_MATCH_READ:
                        begin
                            // High byte first
                            c_nxt.tx_byte = c_r.bp[15:8];
                            c_nxt.sec_byte = c_r.bp[7:0];
                            c_nxt.tx_valid = 1'b1;
                            c_nxt.has_sec = 1'b1;
                            c_nxt.st = S_TX1;
                        end
                        default:
                        begin
                            c_nxt.cmd = c_r.cmd;
                        end
                    endcase
                end
            end
            S_CTRL:
            begin
                if (rx_valid)
                begin
                    // Only control bits move; flags are not written
                    c_nxt.bpen = rx_byte[STAT_BP_ENABLE_POS];
                    c_nxt.force_tag_select_bit = rx_byte[STAT_FORCE_TAG_POS];
                    c_nxt.en = rx_byte[STAT_DEBUG_ENABLE_POS] | hi.active;
                    c_nxt.st = S_IDLE;
                end
            end
            S_ADDR_HI:
            begin
                if (rx_valid)
                begin
                    c_nxt.addr[15:8] = rx_byte;
                    c_nxt.st = S_ADDR_LO;
                end
            end
            S_ADDR_LO, S_WDATA:
            begin
                if (rx_valid)
                begin
                    if (c_r.st == S_ADDR_LO)
                    begin
                        c_nxt.addr[7:0] = rx_byte;
                    end
                    else
                    begin
                        c_nxt.wdata = rx_byte;
                    end
                    if ((c_r.st == S_ADDR_LO) && is_write(c_r.cmd))
                    begin
                        c_nxt.st = S_WDATA;
                    end
                    else
                    begin
                        // Fail flag cleared only by a checked access; any access can set it
                        if (is_checked(c_r.cmd))
                        begin
                            c_nxt.wait_stop_fail_flag = 1'b0;
                        end
                        // Set wins over the clear above
                        if (cpu_entering_wait_stop)
                        begin
                            c_nxt.wait_stop_fail_flag = 1'b1;
                        end
                        if ((c_r.cmd == CMD_CHECKED_MEM_WRITE) && cpu_entering_wait_stop)
                        begin
                            // Write dropped, status still returned
                            c_nxt.tx_byte = status_byte(c_nxt, hi.active, cpu_wait_stop);
                            c_nxt.tx_valid = 1'b1;
                            c_nxt.has_sec = 1'b0;
                            c_nxt.st = S_TX1;
                        end
                        else
                        begin
                            c_nxt.mem_req = 1'b1;
                            c_nxt.mem_we = is_write(c_r.cmd);
                            c_nxt.st = S_MEM;
                        end
                    end
                end
            end
            S_MEM:
            begin
                // The bus wait is the delay slot of the command
                if (mem_ack)
                begin
                    c_nxt.mem_req = 1'b0;
                    c_nxt.mem_we = 1'b0;
                    unique case (c_r.cmd)
                        CMD_MEM_READ:
                        begin
                            c_nxt.tx_byte = mem_rdata;
                            c_nxt.tx_valid = 1'b1;
                            c_nxt.has_sec = 1'b0;
                            c_nxt.st = S_TX1;
                        end
                        CMD_CHECKED_MEM_READ:
                        begin
                            c_nxt.tx_byte = status_byte(c_r, hi.active, cpu_wait_stop);
                            c_nxt.sec_byte = mem_rdata;
                            c_nxt.tx_valid = 1'b1;
                            c_nxt.has_sec = 1'b1;
                            c_nxt.st = S_TX1;
                        end
                        CMD_CHECKED_MEM_WRITE:
                        begin
                            c_nxt.tx_byte = status_byte(c_r, hi.active, cpu_wait_stop);
                            c_nxt.tx_valid = 1'b1;
                            c_nxt.has_sec = 1'b0;
                            c_nxt.st = S_TX1;
                        end
                        default:
                        begin
                            c_nxt.st = S_IDLE;
                        end
                    endcase
                end
            end
            S_TX1:
            begin
                if (tx_ready)
                begin
                    if (c_r.has_sec)
                    begin
                        c_nxt.tx_byte = c_r.sec_byte;
                        c_nxt.st = S_TX2;
                    end
                    else
                    begin
                        c_nxt.tx_valid = 1'b0;
                        c_nxt.st = S_IDLE;
                    end
                end
            end
            S_TX2:
            begin
                if (tx_ready)
                begin
                    c_nxt.tx_valid = 1'b0;
                    c_nxt.st = S_IDLE;
                end
            end
            S_HALT_WAIT:
            begin
                // Commands refused until the instruction can finish
                if (c_r.gap == 5'h00)
                begin
                    c_nxt.st = S_IDLE;
                end
                else
                begin
                    c_nxt.gap = c_r.gap - 5'h01;
                end
            end
            default:
            begin
                c_nxt.st = S_IDLE;
            end
        endcase
        c_nxt.cmd_ready = (c_nxt.st != S_HALT_WAIT) && (c_nxt.st != S_MEM)
            && (c_nxt.st != S_TX1) && (c_nxt.st != S_TX2);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            c_r <= '0;
            c_r.st <= S_IDLE;
            c_r.en <= DEBUG_ENABLE_RESET;
            c_r.bp <= BP_MATCH_RESET;
            c_r.cmd_ready <= 1'b1;
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    // Halt controller flops
    logic active_r;
    logic halt_req_r;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            active_r <= 1'b0;
            halt_req_r <= 1'b0;
        end
        else
        begin
            active_r <= hi.active;
            halt_req_r <= hi.halt_req;
        end
    end

    assign cmd_ready = c_r.cmd_ready;
    assign tx_valid = c_r.tx_valid;
    assign tx_byte = c_r.tx_byte;
    assign mem_req = c_r.mem_req;
    assign mem_we = c_r.mem_we;
    assign mem_addr = c_r.addr;
    assign mem_wdata = c_r.wdata;
    assign halt_req = halt_req_r;
    assign debug_active = active_r;
    assign reset_req = c_r.rst_req;
    // Costs true stop current while debugging
    assign osc_keep_on = c_r.en;
    assign bp_enable = c_r.bpen;
    assign force_tag_select = c_r.force_tag_select_bit;
    assign bp_match = c_r.bp;
endmodule

// >>> logic/dbgc_pkg.sv
/*
 * Shared constants and types of the debug command core: command codes,
 * status byte layout, reset values, timing counts and the state types.
 * Assumes a byte-level serial front end outside this core.
 */
package dbgc_pkg;

    // Command codes
    localparam logic [7:0] CMD_DEBUG_RESET = 8'h18;
    localparam logic [7:0] CMD_HALT = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'he4;
    localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
    localparam logic [7:0] CMD_MEM_READ = 8'he0;
    localparam logic [7:0] CMD_CHECKED_MEM_READ = 8'he1;
    localparam logic [7:0] CMD_MEM_WRITE = 8'hc0;
    localparam logic [7:0] CMD_CHECKED_MEM_WRITE = 8'hc1;
    localparam logic [7:0] CMD_BP_MATCH_READ = 8'he2;

    // Status and control byte layout
    localparam int STAT_DEBUG_ENABLE_POS = 7;
    localparam int STAT_DEBUG_ACTIVE_POS = 6;
    localparam int STAT_BP_ENABLE_POS = 5;
    localparam int STAT_FORCE_TAG_POS = 4;
    localparam int STAT_WAIT_STOP_POS = 2;
    localparam int STAT_WAIT_STOP_FAIL_POS = 1;

    // Reset values
    localparam logic DEBUG_ENABLE_RESET = 1'b0;
    localparam logic [15:0] BP_MATCH_RESET = 16'h0000;

    // Timing counts, in debug clock cycles
    localparam int HALT_GAP_CYCLES = 16;
    localparam int RESET_REQ_CYCLES = 8;
    localparam logic [4:0] HALT_GAP_LOAD = 5'(HALT_GAP_CYCLES - 1);
    localparam logic [3:0] RESET_REQ_LOAD = 4'(RESET_REQ_CYCLES - 1);

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_CTRL = 4'b0001,
        S_ADDR_HI = 4'b0010,
        S_ADDR_LO = 4'b0011,
        S_WDATA = 4'b0100,
        S_MEM = 4'b0101,
        S_TX1 = 4'b0110,
        S_TX2 = 4'b0111,
        S_HALT_WAIT = 4'b1000
    } dbgc_state_type;

    typedef struct packed {
        dbgc_state_type st;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic en;
        logic bpen;
        logic force_tag_select_bit;
        logic wait_stop_fail_flag;
        logic [15:0] bp;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic [7:0] sec_byte;
        logic has_sec;
        logic mem_req;
        logic mem_we;
        logic [4:0] gap;
        logic [3:0] rst_cnt;
        logic rst_req;
        logic halt_pulse;
        logic cmd_ready;
    } dbgc_core_type;

    typedef struct packed {
        logic first;
        logic pend;
        logic active;
        logic boot;
    } dbgc_halt_type;

endpackage

// >>> logic/dbgc_halt_if.sv
/*
 * Link between the command core and its halt controller.
 * Assumes both ends run on the same debug clock.
 */
interface dbgc_halt_if;
    logic halt_cmd;
    logic enable;
    logic pin_level;
    logic instr_done;
    logic active;
    logic halt_req;
    logic boot_halt;

    modport core (
        output halt_cmd,
        output enable,
        output pin_level,
        output instr_done,
        input active,
        input halt_req,
        input boot_halt
    );

    modport halt (
        input halt_cmd,
        input enable,
        input pin_level,
        input instr_done,
        output active,
        output halt_req,
        output boot_halt
    );
endinterface

// >>> logic/dbgc_halt.sv
/*
 * Halt controller: decides entry into active background mode, either
 * from a halt command or from the debug pin level at reset release.
 * Assumes the CPU reports each finished instruction with a pulse.
 */
module dbgc_halt
    import dbgc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    dbgc_halt_if.halt hi
);
    dbgc_halt_type s_r;
    dbgc_halt_type s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.first = 1'b0;
        s_nxt.boot = 1'b0;
        if (s_r.first)
        begin
            // Pin held low through reset: come up halted
            if (!hi.pin_level)
            begin
                s_nxt.active = 1'b1;
                s_nxt.boot = 1'b1;
            end
            // Pin high: user mode, active stays clear
        end
        // Discarded unless enabled
        if (hi.halt_cmd && hi.enable && !s_r.active)
        begin
            s_nxt.pend = 1'b1;
        end
        // Wait for the current instruction to finish
        if (s_r.pend && hi.instr_done)
        begin
            s_nxt.pend = 1'b0;
            s_nxt.active = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_r <= '{first: 1'b1, pend: 1'b0, active: 1'b0, boot: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign hi.active = s_r.active;
    assign hi.halt_req = s_r.pend;
    assign hi.boot_halt = s_r.boot;
endmodule

// >>> bench/dbgc_core_checker.sv
/* Concurrent checks on the debug command core ports.
   Assumes one debug clock and a synchronous active-high reset. */
module dbgc_core_checker
    import dbgc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic cmd_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic halt_req,
    input wire logic debug_active,
    input wire logic reset_req,
    input wire logic osc_keep_on,
    input wire logic bp_enable,
    input wire logic force_tag_select,
    input wire logic [15:0] bp_match
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_take(logic [7:0] b);
        rx_valid && cmd_ready && rx_byte == b;
    endsequence
    // Split gap, long repetitions slow the tools
    sequence s_gap;
        (!cmd_ready) [*8] ##1 (!cmd_ready) [*8];
    endsequence

    a_halt_gap: assert property (s_take(CMD_HALT) |=> s_gap)
        else $error("Byte accepted inside halt gap");
    a_halt_drop: assert property
        (s_take(CMD_HALT) ##0 !osc_keep_on |=> (!halt_req) [*8])
        else $error("Halt raised while disabled");
    a_halt_go: assert property
        (s_take(CMD_HALT) ##0 (osc_keep_on && !debug_active) |-> ##3 halt_req)
        else $error("Enabled halt not requested");
    a_stat_byte: assert property (s_take(CMD_READ_STATUS) |=> tx_valid
        && tx_byte[7] == $past(osc_keep_on) && tx_byte[5] == $past(bp_enable)
        && tx_byte[4] == $past(force_tag_select) && tx_byte[3] == 1'b0 && tx_byte[0] == 1'b0)
        else $error("Status byte wrong");
    a_stat_nobus: assert property (s_take(CMD_READ_STATUS) |=> (!mem_req) [*4])
        else $error("Status read used the bus");
    a_tx_hold: assert property
        (tx_valid && !tx_ready && !$past(tx_ready) |=> tx_valid && $stable(tx_byte))
        else $error("Answer byte dropped early");
    a_rst_len: assert property
        (s_take(CMD_DEBUG_RESET) |=> reset_req [*8] ##1 !reset_req)
        else $error("Reset request length wrong");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_we))
        else $error("Bus request changed before ack");
    a_en_sticky: assert property (debug_active && osc_keep_on |=> osc_keep_on)
        else $error("Enable cleared while active");
    a_bp_high: assert property
        (s_take(CMD_BP_MATCH_READ) |=> tx_valid && tx_byte == bp_match[15:8])
        else $error("Breakpoint high byte wrong");
endmodule

bind dbgc_core dbgc_core_checker u_chk (
    .mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_ready(cmd_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack), .halt_req(halt_req),
    .debug_active(debug_active), .reset_req(reset_req), .osc_keep_on(osc_keep_on),
    .bp_enable(bp_enable), .force_tag_select(force_tag_select), .bp_match(bp_match)
);

// >>> bench/dbgc_mem_model.sv
/* CPU bus model: 256 bytes, acknowledges after a set latency.
   Assumes requests held until the ack pulse. */
module dbgc_mem_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [3:0] cnt = 4'h0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end
    always @(posedge mclk)
    begin
        mem_ack <= 1'b0;
        // Data not held outside ack, so stale reads show
        mem_rdata <= ~mem_rdata;
        if (rst)
            cnt <= 4'h0;
        else if (mem_req && !mem_ack)
        begin
            cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
            if (cnt == lat)
            begin
                mem_ack <= 1'b1;
                if (mem_we)
                    mem[mem_addr[7:0]] <= mem_wdata;
                else
                    mem_rdata <= mem[mem_addr[7:0]];
            end
        end
    end
endmodule

// >>> bench/single_wire_debug_command_core_tb.sv
/* Self-checking bench of the debug command core with a bus model.
   Assumes the ports and constants of dbgc_pkg. */
module single_wire_debug_command_core_tb
    import dbgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic tx_ready = 1'b0;
    logic pin = 1'b1;
    logic ws = 1'b0;
    logic ews = 1'b0;
    logic idone = 1'b0;
    logic bp_wv = 1'b0;
    logic [15:0] bp_wd = 16'h0000;
    logic [3:0] lat = 4'h2;
    logic cmd_ready, tx_valid, mem_req, mem_we, mem_ack, halt_req, debug_active;
    logic reset_req, osc_keep_on, bp_enable, force_tag_select;
    logic [7:0] tx_byte, mem_wdata, mem_rdata;
    logic [15:0] mem_addr, bp_match;
    int error_cnt = 0;
    int checks_done = 0;

    dbgc_core dut (.mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .debug_pin_level(pin),
        .cpu_wait_stop(ws), .cpu_entering_wait_stop(ews), .cpu_instr_done(idone),
        .bp_wr_valid(bp_wv), .bp_wr_data(bp_wd), .halt_req(halt_req),
        .debug_active(debug_active), .reset_req(reset_req), .osc_keep_on(osc_keep_on),
        .bp_enable(bp_enable), .force_tag_select(force_tag_select), .bp_match(bp_match));
    dbgc_mem_model u_mem (.mclk(mclk), .rst(rst), .lat(lat), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Bounded wait on cmd_ready (0) or tx_valid (1)
    task automatic wait_hi(input logic which);
        int i;
        for (i = 0; i < 200 && (which ? tx_valid : cmd_ready) !== 1'b1; i++)
            cyc(1);
        if (i == 200)
        begin
            chk(1'b0, "wait timeout");
            final_report();
        end
    endtask
    task automatic send(input logic [7:0] b);
        wait_hi(1'b0);
        rx_byte = b;
        rx_valid = 1'b1;
        cyc(1);
        rx_valid = 1'b0;
        cyc(1);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] a);
        send(c);
        send(a[15:8]);
        send(a[7:0]);
    endtask
    task automatic get(input logic [7:0] exp);
        wait_hi(1'b1);
        chk(tx_byte === exp, "answer byte");
        tx_ready = 1'b1;
        cyc(1);
        tx_ready = 1'b0;
        cyc(1);
    endtask
    task automatic stat(input logic [7:0] exp);
        send(CMD_READ_STATUS);
        get(exp);
    endtask
    task automatic ctrl(input logic [7:0] v);
        send(CMD_WRITE_CONTROL);
        send(v);
    endtask

    task automatic t_reset();
        cyc(3);
        chk(cmd_ready === 1'b1 && tx_valid === 1'b0 && osc_keep_on === 1'b0, "reset");
        chk(debug_active === 1'b0 && halt_req === 1'b0, "not running");
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        logic [7:0] junk [3] = '{8'h33, 8'h08, 8'hff};
        ctrl(8'h76);
        stat(8'h30);
        chk(bp_enable === 1'b1 && force_tag_select === 1'b1, "bp bits");
        ws = 1'b1;
        stat(8'h34);
        ws = 1'b0;
        foreach (junk[i])
            send(junk[i]);
        stat(8'h30);
        $display("test control done");
    endtask
    task automatic t_bp();
        bp_wv = 1'b1;
        bp_wd = 16'ha5c3;
        cyc(1);
        bp_wv = 1'b0;
        cyc(1);
        chk(bp_match === 16'ha5c3, "bp register");
        send(CMD_BP_MATCH_READ);
        get(8'ha5);
        get(8'hc3);
        $display("test breakpoint done");
    endtask
    task automatic t_halt_off();
        logic bad;
        bad = 1'b0;
        send(CMD_HALT);
        rx_byte = CMD_READ_STATUS;
        rx_valid = 1'b1;
        cyc(1);
        rx_valid = 1'b0;
        repeat (20)
        begin
            bad |= (halt_req !== 1'b0) || (tx_valid !== 1'b0);
            cyc(1);
        end
        chk(!bad, "halt or answer in gap");
        $display("test halt disabled done");
    endtask
    task automatic t_mem();
        lat = 4'h5;
        cmd(CMD_MEM_WRITE, 16'h0012);
        send(8'h3c);
        wait_hi(1'b0);
        chk(u_mem.mem[8'h12] === 8'h3c && tx_valid === 1'b0, "plain write");
        cmd(CMD_MEM_READ, 16'h0012);
        get(8'h3c);
        cyc(3);
        chk(tx_valid === 1'b0, "extra byte");
        lat = 4'h0;
        cmd(CMD_CHECKED_MEM_READ, 16'h0034);
        get(8'h30);
        get(8'h6e);
        ews = 1'b1;
        cmd(CMD_CHECKED_MEM_WRITE, 16'h0040);
        send(8'h77);
        get(8'h32);
        ews = 1'b0;
        chk(u_mem.mem[8'h40] === 8'h1a, "write not cancelled");
        $display("test memory done");
    endtask
    task automatic t_halt_on();
        ctrl(8'h80);
        stat(8'h82);
        chk(osc_keep_on === 1'b1, "oscillator hold");
        send(CMD_HALT);
        cyc(2);
        chk(halt_req === 1'b1 && debug_active === 1'b0, "halt pending");
        idone = 1'b1;
        cyc(1);
        idone = 1'b0;
        cyc(2);
        chk(debug_active === 1'b1, "halted");
        ctrl(8'h00);
        stat(8'hc2);
        cmd(CMD_CHECKED_MEM_WRITE, 16'h0040);
        send(8'h77);
        get(8'hc0);
        chk(u_mem.mem[8'h40] === 8'h77, "retried write");
        $display("test halt enabled done");
    endtask
    task automatic t_dbg_reset(input logic lvl);
        int n;
        n = 0;
        pin = lvl;
        wait_hi(1'b0);
        rx_byte = CMD_DEBUG_RESET;
        rx_valid = 1'b1;
        cyc(1);
        rx_valid = 1'b0;
        for (int i = 0; i < 20; i++)
        begin
            n += int'(reset_req === 1'b1);
            cyc(1);
        end
        chk(n == 8, "reset request length");
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(4);
        chk(debug_active === ~lvl && osc_keep_on === ~lvl, "mode after reset");
        pin = 1'b1;
        $display("test debug reset done");
    endtask

    initial
    begin
        cyc(5);
        rst = 1'b0;
        t_reset();
        t_ctrl();
        t_bp();
        t_halt_off();
        t_mem();
        t_halt_on();
        t_dbg_reset(1'b0);
        t_dbg_reset(1'b1);
        final_report();
    end
endmodule
